// [core/flash_erase_pkg.sv]
// constants and types shared by the flash erase controller
package flash_erase_pkg;

	// register byte addresses on the avalon slave
	localparam logic [3:0] ctrl_stat_addr   = 4'h0;
	localparam logic [3:0] page_sel_addr    = 4'h4;
	localparam logic [3:0] sect_prot_addr   = 4'h8;
	localparam logic [3:0] mode_addr        = 4'hC;

	// control command codes
	localparam logic [7:0] cmd_unlock_1     = 8'h73;
	localparam logic [7:0] cmd_unlock_2     = 8'h8C;
	localparam logic [7:0] cmd_page_erase   = 8'h95;
	localparam logic [7:0] cmd_mass_erase   = 8'h63;

	// controller_state_code values
	localparam logic [5:0] code_locked      = 6'h00;
	localparam logic [5:0] code_first       = 6'h01;
	localparam logic [5:0] code_second      = 6'h02;
	localparam logic [5:0] code_unlocked    = 6'h03;
	localparam logic [5:0] code_page_erase  = 6'h10;
	localparam logic [5:0] code_mass_erase  = 6'h20;

	// array geometry: 8 pages of 512 bytes
	localparam int         page_bytes       = 512;
	localparam int         page_count       = 8;
	localparam int         addr_width       = 12;
	localparam int         page_bits        = 3;

	// mode register fields
	localparam int         mode_mass_en_bit = 0;
	localparam int         mode_bypass_bit  = 1;
	localparam int         mode_wprot_bit   = 2;

	// reset values
	localparam logic [7:0] page_sel_reset   = 8'h00;
	localparam logic [7:0] sect_prot_reset  = 8'h00;
	localparam logic [7:0] mode_reset       = 8'h00;

	// erase durations
	localparam int         page_erase_us    = 10;
	localparam int         mass_erase_us    = 40;
	localparam int         clk_mhz          = 100;
	localparam int         page_erase_cyc   = page_erase_us * clk_mhz;
	localparam int         mass_erase_cyc   = mass_erase_us * clk_mhz;
	localparam int         count_width      = 16;

	typedef enum logic [5:0] {
		st_locked   = 6'b000001,
		st_first    = 6'b000010,
		st_second   = 6'b000100,
		st_unlocked = 6'b001000,
		st_page     = 6'b010000,
		st_mass     = 6'b100000
	} ctrl_state_t;

endpackage

// [core/erase_if.sv]
// interface between the sequencer and the array erase engine
`timescale 1ns/1ps
interface erase_if;
	logic                                  start;
	logic                                  mass;
	logic [flash_erase_pkg::page_bits-1:0] page;
	logic [flash_erase_pkg::count_width-1:0] cycles;
	logic                                  busy;
	logic                                  done;

	modport ctrl (
		output start,
		output mass,
		output page,
		output cycles,
		input  busy,
		input  done
	);
	modport engine (
		input  start,
		input  mass,
		input  page,
		input  cycles,
		output busy,
		output done
	);
endinterface

// [core/erase_engine.sv]
// timed erase engine: counts out the erase and drives the array strobes
`timescale 1ns/1ps
module erase_engine (
	// clock and reset
	input  wire logic                                 clk_in,
	input  wire logic                                 rst_b_in,
	// sequencer side
	erase_if.engine                                   ctl,
	// array side
	output logic                                      arr_erase_out,
	output logic                                      arr_mass_out,
	output logic [flash_erase_pkg::page_bits-1:0]     arr_page_out
);

	logic [flash_erase_pkg::count_width-1:0] cnt_q;
	logic                                    busy_q;
	logic                                    done_q;

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			cnt_q         <= '0;
			busy_q        <= 1'b0;
			done_q        <= 1'b0;
			arr_erase_out <= 1'b0;
			arr_mass_out  <= 1'b0;
			arr_page_out  <= '0;
		end else begin
			done_q <= 1'b0;
			if (!busy_q && ctl.start) begin
				// page erase hits the whole page named by the selector
				cnt_q         <= ctl.cycles;
				busy_q        <= 1'b1;
				arr_erase_out <= 1'b1;
				arr_mass_out  <= ctl.mass;
				arr_page_out  <= ctl.page;
			end else if (busy_q) begin
				if (cnt_q <= 16'h0001) begin
					busy_q        <= 1'b0;
					done_q        <= 1'b1;
					arr_erase_out <= 1'b0;
					arr_mass_out  <= 1'b0;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
		end
	end

	assign ctl.busy = busy_q;
	assign ctl.done = done_q;

endmodule

// [core/flash_erase_controller.sv]
// flash erase controller: unlock sequencer, commands, protection, bypass
`timescale 1ns/1ps

// Operation
// - erase unit is one 512-byte page
// - page erase leaves page bytes at FFH
// - page erase targets the page selector
// - protected sectors refuse page erase
// - 95h when unlocked starts page erase
// - core held idle during any erase; a bypass pin erase leaves the core running
// - page erase end relocks controller
// - mass erase only via debug access; in bypass the pins mass erase without it
// - mass erase sets whole array FFH
// - 63H when unlocked starts mass erase
// - mass erase polled, then relocks
// - bypass routes flash strobes to pins
// - bypass still allows pin page erase
// - debug access ignores write protect
// - debug access ignores sector protect
// - unlock is 73H then 8CH
// - status 010xxx page, 100xxx mass
// - page erase covers selected top bits
// - status read, control write, one address
module flash_erase_controller #(
	parameter int page_cycles = flash_erase_pkg::page_erase_cyc,
	parameter int mass_cycles = flash_erase_pkg::mass_erase_cyc
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	// access source
	input  wire logic        debug_access_unit_in,
	// core stall
	output logic             core_idle_out,
	// bypass pins
	input  wire logic        pin_erase_in,
	input  wire logic        pin_mass_in,
	input  wire logic [2:0]  pin_page_in,
	// flash array strobes
	output logic             arr_erase_out,
	output logic             arr_mass_out,
	output logic [2:0]       arr_page_out,
	output logic             write_prot_active_out
);

	////////////////////////////////////////////////////////////////////////
	// registers

	flash_erase_pkg::ctrl_state_t state_q;
	logic [7:0]  erase_page_select_q;
	logic [7:0]  sect_prot_q;
	logic [7:0]  mode_q;
	logic [31:0] rdata_q;
	logic        ack_q;
	logic        start_q;
	logic        mass_q;

	erase_if eng ();

	logic        eng_erase;
	logic        eng_mass;
	logic [2:0]  eng_page;

	logic        bus_req;
	logic        wr_ok;
	logic [7:0]  wbyte;
	logic        bypass;
	logic        sector_locked;

	// one access per req; ack in the cycle after the request is seen
	assign bus_req = (avs_read_in || avs_write_in) && !ack_q;
	assign avs_waitrequest_out = !ack_q;
	assign wr_ok = avs_write_in && ack_q && avs_byteenable_in[0];
	assign wbyte = avs_writedata_in[7:0];
	assign bypass = mode_q[flash_erase_pkg::mode_bypass_bit];

	function automatic logic is_addr(input logic [3:0] a,
			input logic [3:0] b);
		return a == b;
	endfunction

	// debug access overrides both protect mechanisms
	assign sector_locked = sect_prot_q[erase_page_select_q[2:0]]
		&& !debug_access_unit_in;
	assign write_prot_active_out =
		mode_q[flash_erase_pkg::mode_wprot_bit]
		&& !debug_access_unit_in;

	////////////////////////////////////////////////////////////////////////
	// bus handshake and read data

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_req;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (bus_req && avs_read_in) begin
			if (is_addr(avs_address_in,
					flash_erase_pkg::ctrl_stat_addr)) begin
				rdata_q <= {26'h0, status_code(state_q)};
			end else if (is_addr(avs_address_in,
					flash_erase_pkg::page_sel_addr)) begin
				rdata_q <= {24'h0, erase_page_select_q};
			end else if (is_addr(avs_address_in,
					flash_erase_pkg::sect_prot_addr)) begin
				rdata_q <= {24'h0, sect_prot_q};
			end else if (is_addr(avs_address_in,
					flash_erase_pkg::mode_addr)) begin
				rdata_q <= {24'h0, mode_q};
			end else begin
				rdata_q <= 32'h0000_0000;
			end
		end
	end
	assign avs_readdata_out = rdata_q;

	function automatic logic [5:0] status_code(
			input flash_erase_pkg::ctrl_state_t s);
		case (s)
			flash_erase_pkg::st_locked:   status_code =
				flash_erase_pkg::code_locked;
			flash_erase_pkg::st_first:    status_code =
				flash_erase_pkg::code_first;
			flash_erase_pkg::st_second:   status_code =
				flash_erase_pkg::code_second;
			flash_erase_pkg::st_unlocked: status_code =
				flash_erase_pkg::code_unlocked;
			flash_erase_pkg::st_page:     status_code =
				flash_erase_pkg::code_page_erase;
			flash_erase_pkg::st_mass:     status_code =
				flash_erase_pkg::code_mass_erase;
			default:                      status_code =
				flash_erase_pkg::code_locked;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			erase_page_select_q <= flash_erase_pkg::page_sel_reset;
		end else if (wr_ok && is_addr(avs_address_in,
				flash_erase_pkg::page_sel_addr)) begin
			erase_page_select_q <= wbyte;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sect_prot_q <= flash_erase_pkg::sect_prot_reset;
		end else if (wr_ok && is_addr(avs_address_in,
				flash_erase_pkg::sect_prot_addr)) begin
			// set-only, so running code cannot unprotect a page
			sect_prot_q <= sect_prot_q | wbyte;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			mode_q <= flash_erase_pkg::mode_reset;
		end else if (wr_ok && is_addr(avs_address_in,
				flash_erase_pkg::mode_addr)) begin
			mode_q <= {5'h00, wbyte[2:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command sequencer

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			state_q <= flash_erase_pkg::st_locked;
			start_q <= 1'b0;
			mass_q  <= 1'b0;
		end else begin
			start_q <= 1'b0;
			case (state_q)
				flash_erase_pkg::st_locked: begin
					if (wr_ok && is_addr(avs_address_in,
							flash_erase_pkg::ctrl_stat_addr)
							&& wbyte == flash_erase_pkg::cmd_unlock_1) begin
						state_q <= flash_erase_pkg::st_first;
					end
				end
				flash_erase_pkg::st_first: begin
					if (wr_ok && is_addr(avs_address_in,
							flash_erase_pkg::ctrl_stat_addr)) begin
						if (wbyte == flash_erase_pkg::cmd_unlock_2) begin
							state_q <= flash_erase_pkg::st_second;
						end else begin
							state_q <= flash_erase_pkg::st_locked;
						end
					end
				end
				flash_erase_pkg::st_second: begin
					// one settle cycle, then unlocked
					state_q <= flash_erase_pkg::st_unlocked;
				end
				flash_erase_pkg::st_unlocked: begin
					if (wr_ok && is_addr(avs_address_in,
							flash_erase_pkg::ctrl_stat_addr)) begin
						if (wbyte == flash_erase_pkg::cmd_page_erase
								&& !sector_locked && !bypass) begin
							state_q <= flash_erase_pkg::st_page;
							start_q <= 1'b1;
							mass_q  <= 1'b0;
						end else if (wbyte == flash_erase_pkg::cmd_mass_erase
								&& debug_access_unit_in && !bypass
								&& mode_q[flash_erase_pkg::mode_mass_en_bit])
								begin
							state_q <= flash_erase_pkg::st_mass;
							start_q <= 1'b1;
							mass_q  <= 1'b1;
						end else begin
							state_q <= flash_erase_pkg::st_locked;
						end
					end
				end
				flash_erase_pkg::st_page: begin
					if (eng.done) begin
						state_q <= flash_erase_pkg::st_locked;
					end
				end
				flash_erase_pkg::st_mass: begin
					if (eng.done) begin
						state_q <= flash_erase_pkg::st_locked;
					end
				end
				default: state_q <= flash_erase_pkg::st_locked;
			endcase
		end
	end

	// core idles from start through done
	assign core_idle_out = (state_q == flash_erase_pkg::st_page)
		|| (state_q == flash_erase_pkg::st_mass);

	////////////////////////////////////////////////////////////////////////
	// erase engine and bypass mux

	assign eng.start  = start_q;
	assign eng.mass   = mass_q;
	assign eng.page   = erase_page_select_q[2:0];
	assign eng.cycles = mass_q
		? 16'(mass_cycles) : 16'(page_cycles);

	erase_engine u_engine (
		.clk_in        (clk_in),
		.rst_b_in      (rst_b_in),
		.ctl           (eng),
		.arr_erase_out (eng_erase),
		.arr_mass_out  (eng_mass),
		.arr_page_out  (eng_page)
	);

	// bypass hands the array strobes to the pins; no protection applies
	assign arr_erase_out = bypass ? pin_erase_in : eng_erase;
	assign arr_mass_out  = bypass ? pin_mass_in  : eng_mass;
	assign arr_page_out  = bypass ? pin_page_in  : eng_page;

endmodule

// [tb/flash_array_model.sv]
// behavioural flash array answering the erase strobes
`timescale 1ns/1ps
module flash_array_model (
	// clock
	input  wire logic       clk_in,
	// erase strobes
	input  wire logic       arr_erase_in,
	input  wire logic       arr_mass_in,
	input  wire logic [2:0] arr_page_in
);
	logic [7:0] mem_q [0:4095];

	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem_q[i] = 8'h00;
		end
	end

	// a strobe erases the page it names, all 512 bytes, or the whole array
	always @(posedge clk_in) begin
		for (int i = 0; i < 4096; i++) begin
			if (arr_mass_in
					|| (arr_erase_in && i[11:9] == arr_page_in)) begin
				mem_q[i] <= 8'hFF;
			end
		end
	end
endmodule

// [tb/flash_erase_controller_assertions.sv]
// port assertions for the flash erase controller
`timescale 1ns/1ps
module flash_erase_controller_assertions #(
	parameter int page_cycles = 8,
	parameter int mass_cycles = 16
) (
	input wire logic        clk_in,
	input wire logic        rst_b_in,
	input wire logic [3:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic        debug_access_unit_in,
	input wire logic        core_idle_out,
	input wire logic        arr_erase_out,
	input wire logic        arr_mass_out,
	input wire logic [2:0]  arr_page_out,
	input wire logic        write_prot_active_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	logic [15:0] run_q;
	logic [15:0] idle_q;

	always_ff @(posedge clk_in) begin
		if (!rst_b_in || !(arr_erase_out || arr_mass_out)) begin
			run_q <= 16'h0000;
		end else begin
			run_q <= run_q + 16'h0001;
		end
	end

	// a stuck stall would hang the core, so bound it
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || !core_idle_out) begin
			idle_q <= 16'h0000;
		end else begin
			idle_q <= idle_q + 16'h0001;
		end
	end

	sequence s_req;
		$rose(avs_read_in || avs_write_in);
	endsequence
	sequence s_ack;
		!avs_waitrequest_out ##1 avs_waitrequest_out;
	endsequence

	ack_once_a: assert property (s_req |=> s_ack)
		else $error("access not answered in one cycle");
	stat_rsvd_a: assert property (avs_read_in && !avs_waitrequest_out
		&& avs_address_in == 4'h0 |-> avs_readdata_out[31:6] == 26'h0)
		else $error("status upper bits not zero");
	gap_read_a: assert property (avs_read_in && !avs_waitrequest_out
		&& avs_address_in[1:0] != 2'h0 |-> avs_readdata_out == 32'h0)
		else $error("unmapped read not zero");
	idle_strobe_a: assert property ($rose(core_idle_out) |=>
		arr_erase_out || arr_mass_out) else $error("stall without erase");
	page_len_a: assert property ($fell(arr_erase_out) &&
		$past(core_idle_out) && !$past(arr_mass_out) |-> run_q == page_cycles)
		else $error("page erase length wrong");
	mass_len_a: assert property ($fell(arr_mass_out) &&
		$past(core_idle_out) |-> run_q == mass_cycles)
		else $error("mass erase length wrong");
	idle_bound_a: assert property (core_idle_out |->
		idle_q <= mass_cycles + 2) else $error("core stalled too long");
	page_hold_a: assert property (arr_erase_out && $past(arr_erase_out)
		&& core_idle_out |-> $stable(arr_page_out))
		else $error("erase page moved");
	mass_dbg_a: assert property ($rose(arr_mass_out) && core_idle_out
		|-> $past(debug_access_unit_in, 2)) else $error("mass erase not debug");
	wprot_dbg_a: assert property (debug_access_unit_in &&
		$past(debug_access_unit_in) |-> !write_prot_active_out)
		else $error("write protect under debug");
endmodule

bind flash_erase_controller flash_erase_controller_assertions #(
	.page_cycles(page_cycles), .mass_cycles(mass_cycles)
) i_flash_erase_controller_assertions (
	.clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in,
	.avs_readdata_out, .avs_waitrequest_out, .debug_access_unit_in,
	.core_idle_out, .arr_erase_out, .arr_mass_out, .arr_page_out,
	.write_prot_active_out
);

// [tb/test_flash_erase_controller.sv]
// register-level test of the flash erase controller
`timescale 1ns/1ps
module test_flash_erase_controller;
	localparam int pc = 8;
	localparam int mc = 16;

	logic        clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic [3:0]  avs_address_in = 4'h0;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic        dbg = 1'b0;
	logic        core_idle_out;
	logic        pin_erase_in = 1'b0;
	logic        pin_mass_in = 1'b0;
	logic [2:0]  pin_page_in = 3'h0;
	logic        arr_erase_out;
	logic        arr_mass_out;
	logic [2:0]  arr_page_out;
	logic        write_prot_active_out;
	logic [31:0] q;
	int          n_fail = 0;
	int          check_count = 0;

	always #5 clk_in = ~clk_in;

	flash_erase_controller #(.page_cycles(pc), .mass_cycles(mc))
	i_flash_erase_controller (
		.clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_byteenable_in(4'h1), .avs_readdata_out,
		.avs_waitrequest_out, .debug_access_unit_in(dbg), .core_idle_out,
		.pin_erase_in, .pin_mass_in, .pin_page_in, .arr_erase_out,
		.arr_mass_out, .arr_page_out, .write_prot_active_out
	);
	flash_array_model i_flash_array_model (
		.clk_in, .arr_erase_in(arr_erase_out), .arr_mass_in(arr_mass_out),
		.arr_page_in(arr_page_out)
	);

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// request held until waitrequest is seen low at a rising edge
	task automatic acc(input logic w, input logic [3:0] a,
		input logic [7:0] d);
		// an edge passes first, so a release never meets a new request
		@(posedge clk_in);
		avs_address_in   <= a;
		avs_writedata_in <= {24'h0, d};
		avs_write_in     <= w;
		avs_read_in      <= !w;
		@(posedge clk_in);
		// read right after the edge: these are the values it sampled
		while (avs_waitrequest_out !== 1'b0) begin
			@(posedge clk_in);
		end
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in  <= 1'b0;
	endtask

	task automatic unlock;
		acc(1, 4'h0, 8'h73);
		acc(1, 4'h0, 8'h8C);
	endtask

	// debugger side waits for the status to come back to locked
	task automatic poll;
		int n;
		n = 0;
		q = 32'h1;
		while (q !== 32'h0 && n < 60) begin
			acc(0, 4'h0, 8'h00);
			n++;
		end
		chk("relocked", q, 32'h0);
	endtask

	task automatic page_is(input int p, input logic [7:0] v);
		int bad;
		bad = 0;
		for (int i = 0; i < 512; i++) begin
			if (i_flash_array_model.mem_q[p * 512 + i] !== v) bad++;
		end
		chk("page bytes", bad, 0);
	endtask

	initial begin
		repeat (12) @(posedge clk_in);
		rst_b_in <= 1'b1;
		for (int a = 0; a < 16; a += 2) begin
			acc(0, a[3:0], 8'h00);
			chk("reset read", q, 32'h0);
		end
		acc(1, 4'h0, 8'h95);
		acc(0, 4'h0, 8'h00);
		chk("locked cmd", q, 32'h0);
		acc(1, 4'h4, 8'h05);
		acc(1, 4'h0, 8'h73);
		acc(0, 4'h0, 8'h00);
		chk("first key", q, 32'h1);
		acc(1, 4'h0, 8'h8C);
		acc(0, 4'h0, 8'h00);
		chk("unlocked", q, 32'h3);
		acc(1, 4'h0, 8'h95);
		acc(0, 4'h0, 8'h00);
		chk("page status", q, 32'h10);
		chk("core idle", core_idle_out, 1'b1);
		poll();
		chk("core resumed", core_idle_out, 1'b0);
		page_is(5, 8'hFF);
		page_is(4, 8'h00);
		acc(1, 4'h0, 8'h95);
		acc(0, 4'h0, 8'h00);
		chk("needs unlock", q, 32'h0);
		acc(1, 4'h8, 8'h04);
		acc(1, 4'h4, 8'h02);
		unlock();
		acc(1, 4'h0, 8'h95);
		acc(0, 4'h0, 8'h00);
		chk("protected", q, 32'h0);
		page_is(2, 8'h00);
		dbg <= 1'b1;
		unlock();
		acc(1, 4'h0, 8'h95);
		poll();
		page_is(2, 8'hFF);
		acc(1, 4'hC, 8'h04);
		// the mode write lands at the edge acc returns on; one more edge shows it
		@(posedge clk_in);
		chk("wprot dbg", write_prot_active_out, 1'b0);
		dbg <= 1'b0;
		repeat (2) @(posedge clk_in);
		chk("wprot", write_prot_active_out, 1'b1);
		acc(1, 4'hC, 8'h01);
		unlock();
		acc(1, 4'h0, 8'h63);
		acc(0, 4'h0, 8'h00);
		chk("mass no dbg", q, 32'h0);
		page_is(0, 8'h00);
		dbg <= 1'b1;
		unlock();
		acc(1, 4'h0, 8'h63);
		acc(0, 4'h0, 8'h00);
		chk("mass status", q, 32'h20);
		chk("mass idle", core_idle_out, 1'b1);
		poll();
		for (int p = 0; p < 8; p++) page_is(p, 8'hFF);
		acc(1, 4'hC, 8'h02);
		pin_erase_in <= 1'b1;
		pin_page_in <= 3'h3;
		pin_mass_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		chk("pin erase", arr_erase_out, 1'b1);
		chk("pin page", arr_page_out, 3'h3);
		chk("pin mass", arr_mass_out, 1'b1);
		complete_run();
	end

	initial begin
		repeat (20000) @(posedge clk_in);
		n_fail++;
		complete_run();
	end
endmodule
